// ---- logic/hbf_regs.svh ----
// Bit positions, sizes and timing figures of the half-bridge fault logic
`ifndef HBF_REGS_SVH
`define HBF_REGS_SVH
`define HBF_N_OUT        12
`define HBF_N_SENSOR     6
`define HBF_N_SUPPLY     2
`define HBF_WORD_W       16
`define HBF_BIT_CNT_W    5
`define HBF_FRAME_MASK   4'h0
`define HBF_CLK_MHZ      125
`define HBF_OC_LONG_US   200
`define HBF_OC_SHORT_US  25
`define HBF_UL_US        350
`define HBF_CNT_W        16
`define HBF_RST_WORD     16'h0000
`endif

// ---- logic/hbf_pkg.sv ----
// Types shared by the half-bridge fault logic
`include "hbf_regs.svh"
package hbf_pkg;
  // Command word as shifted in: overvoltage enable, underload shutdown, delay select, outputs
  typedef struct packed {
    logic                   overvoltage_shutdown_enable;
    logic                   underload_shutdown;
    logic                   overcurrent_delay_select;
    logic [`HBF_N_OUT-1:0]  output_on;
    logic                   status_reset_bit;
  } hbf_cmd_t;
  // Status word as shifted out, thermal warning first
  typedef struct packed {
    logic                   supply_fail_flag;
    logic                   underload_flag;
    logic                   overload_flag;
    logic [`HBF_N_OUT-1:0]  output_state;
    logic                   thermal_warning_flag;
  } hbf_status_t;
  // Asynchronous analog and pin inputs, synchronised together
  typedef struct packed {
    logic [`HBF_N_SUPPLY-1:0] undervoltage;
    logic [`HBF_N_SUPPLY-1:0] overvoltage;
    logic [`HBF_N_SENSOR-1:0] thermal_warn;
    logic [`HBF_N_SENSOR-1:0] thermal_shutdown;
    logic [`HBF_N_OUT-1:0]    overcurrent;
    logic [`HBF_N_OUT-1:0]    underload;
    logic                     spi_clk;
    logic                     chip_select_n;
  } hbf_sense_t;
  typedef enum logic [2:0] {
    HBF_ST_IDLE  = 3'b001,
    HBF_ST_FRAME = 3'b010,
    HBF_ST_END   = 3'b100
  } hbf_state_t;
endpackage : hbf_pkg

// ---- logic/hbf_protect.sv ----
// Fault protection and status logic of a six-pair half-bridge driver
//
// Contract
// - Persistent overcurrent latches output off, sets overload
// - Overcurrent latch released only by status reset
// - Delay select: zero 200 us, one 25 us
// - Delay chosen at timer start is kept
// - Expired underload always sets underload flag
// - Underload latches output off only if enabled
// - One shared underload timer for all channels
// - Underload flag cleared only by status reset
// - Undervoltage sets supply fail, forces outputs off
// - Supplies good again restore programmed outputs
// - Supply fail stays latched until status reset
// - Overvoltage flags always, shuts down if enabled
// - Overvoltage recovery restores programmed outputs
// - Any thermal warning sets flag, outputs stay
// - Thermal shutdown stops all, recovery resumes selection
// - Thermal warning flag held until status reset
// - Chip select fall presents warning without clocks
// - Early readout: zero no warning, one warning
// - No output switched on during thermal shutdown
// - Status reset acts at chip select rise
`include "hbf_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module hbf_protect #(
  parameter int OC_LONG_CYC = `HBF_OC_LONG_US * `HBF_CLK_MHZ,
  parameter int UL_CYC      = `HBF_UL_US * `HBF_CLK_MHZ
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    spi_clk,
  input  wire logic                    chip_select_n,
  input  wire logic                    serial_in,
  input  wire hbf_pkg::hbf_sense_t     sense_raw,
  output logic [`HBF_N_OUT-1:0]        driver_output,
  output logic                         serial_out,
  output logic                         serial_out_oe_n,
  output hbf_pkg::hbf_status_t         status_word,
  output hbf_pkg::hbf_cmd_t            config_word
);
  import hbf_pkg::*;

  localparam int OC_SHORT_CYC = `HBF_OC_SHORT_US * `HBF_CLK_MHZ;
  localparam int CNT_W        = `HBF_CNT_W;

  generate
    if (OC_LONG_CYC < 1 || UL_CYC < 1 || OC_LONG_CYC >= 2**CNT_W || UL_CYC >= 2**CNT_W) begin : g_chk
      $error("hbf_protect: delay count does not fit the timer width");
    end
    if ($bits(hbf_cmd_t) != `HBF_WORD_W || $bits(hbf_status_t) != `HBF_WORD_W) begin : g_chk_w
      $error("hbf_protect: command or status word does not match the frame width");
    end
  endgenerate

  // Latched flag: a new event wins over a clear in the same cycle
  function automatic logic sticky(input logic set, input logic held, input logic clr);
    return set || (held && !clr);
  endfunction : sticky

  // Counts link clock edges; the top bit records that a whole word has passed
  function automatic logic [`HBF_BIT_CNT_W-1:0] bit_step(input logic [`HBF_BIT_CNT_W-1:0] c);
    logic [`HBF_BIT_CNT_W-2:0] low;
    low = c[`HBF_BIT_CNT_W-2:0];
    return {c[`HBF_BIT_CNT_W-1] | (&low), low + 1'b1};
  endfunction : bit_step

  // ---------------- Link domain: shifting only
  // No reset here: the link clock may be still during reset, a valid frame rewrites
  // the whole word, and the core counts the bits on its own clock
  logic [`HBF_WORD_W-1:0]     rx_shift_q;
  logic [`HBF_WORD_W-1:0]     rx_shift_d;

  always_comb begin
    rx_shift_d = rx_shift_q;
    if (!chip_select_n) begin
      rx_shift_d = {rx_shift_q[`HBF_WORD_W-2:0], serial_in};
    end
  end

  always_ff @(posedge spi_clk) begin
    rx_shift_q <= rx_shift_d;
  end

  // ---------------- Core domain synchronisers
  hbf_sense_t                 sense_m_q;
  hbf_sense_t                 sense_q;

  always_ff @(posedge clk) begin
    sense_m_q <= sense_raw;
    sense_q   <= sense_m_q;
  end

  // ---------------- Core state
  hbf_state_t                 state_q;
  hbf_state_t                 state_d;
  logic                       cs_prev_q;
  logic                       cs_prev_d;
  logic                       sclk_prev_q;
  logic                       sclk_prev_d;
  logic [`HBF_BIT_CNT_W-1:0]  frame_bits_q;
  logic [`HBF_BIT_CNT_W-1:0]  frame_bits_d;
  logic                       sclk_rise;
  logic                       sclk_fall;
  logic                       cs_fall;
  logic                       cs_rise;
  hbf_cmd_t                   cfg_q;
  hbf_cmd_t                   cfg_d;
  hbf_cmd_t                   rx_cmd;
  logic                       frame_ok;
  logic                       srr_clr;
  logic [`HBF_WORD_W-1:0]     tx_q;
  logic [`HBF_WORD_W-1:0]     tx_d;
  logic                       oe_n_q;
  logic                       oe_n_d;
  hbf_status_t                status_q;
  hbf_status_t                status_d;
  logic [`HBF_N_OUT-1:0]      drv_q;
  logic [`HBF_N_OUT-1:0]      drv_d;
  logic [`HBF_N_OUT-1:0]      oc_off;
  logic [`HBF_N_OUT-1:0]      oc_trip;
  logic [`HBF_N_OUT-1:0]      ul_off_q;
  logic [`HBF_N_OUT-1:0]      ul_off_d;
  logic [CNT_W-1:0]           ul_cnt_q;
  logic [CNT_W-1:0]           ul_cnt_d;
  logic                       ul_any;
  logic                       ul_expired;
  logic                       uv_any;
  logic                       ov_any;
  logic                       tsd_any;
  logic                       force_off;

  assign sclk_rise  = !sclk_prev_q && sense_q.spi_clk;
  assign sclk_fall  = sclk_prev_q && !sense_q.spi_clk;
  assign cs_fall    = cs_prev_q && !sense_q.chip_select_n;
  assign cs_rise    = !cs_prev_q && sense_q.chip_select_n;
  assign rx_cmd     = hbf_cmd_t'(rx_shift_q);
  // Nonzero sixteen-bit multiples only; the word is still since the link clock has stopped
  assign frame_ok   = (state_q == HBF_ST_END) && frame_bits_q[`HBF_BIT_CNT_W-1] &&
                      (frame_bits_q[`HBF_BIT_CNT_W-2:0] == `HBF_FRAME_MASK);
  assign srr_clr    = frame_ok && rx_cmd.status_reset_bit;

  // Frame tracking and command capture
  always_comb begin
    state_d      = state_q;
    frame_bits_d = frame_bits_q;
    cfg_d        = cfg_q;
    cs_prev_d    = sense_q.chip_select_n;
    sclk_prev_d  = sense_q.spi_clk;
    oe_n_d       = sense_q.chip_select_n;
    case (state_q)
      HBF_ST_IDLE: begin
        if (cs_fall) begin
          state_d      = HBF_ST_FRAME;
          frame_bits_d = '0;
        end
      end
      HBF_ST_FRAME: begin
        // Both link pins pass the same synchroniser, so edge order is kept
        if (sclk_rise) begin
          frame_bits_d = bit_step(frame_bits_q);
        end
        if (cs_rise) begin
          state_d = HBF_ST_END;
        end
      end
      HBF_ST_END: begin
        state_d = HBF_ST_IDLE;
        if (frame_ok) begin
          cfg_d = rx_cmd;
        end
      end
      default: begin
        state_d = HBF_ST_IDLE;
      end
    endcase
    if (reset) begin
      state_d      = HBF_ST_IDLE;
      frame_bits_d = '0;
      cfg_d        = hbf_cmd_t'(`HBF_RST_WORD);
      cs_prev_d    = 1'b1;
      sclk_prev_d  = 1'b0;
      oe_n_d       = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    state_q      <= state_d;
    frame_bits_q <= frame_bits_d;
    cfg_q        <= cfg_d;
    cs_prev_q    <= cs_prev_d;
    sclk_prev_q  <= sclk_prev_d;
    oe_n_q       <= oe_n_d;
  end

  // Per-driver overcurrent timer with the delay frozen at start
  generate
    for (genvar i = 0; i < `HBF_N_OUT; i++) begin : g_oc
      logic [CNT_W-1:0] cnt_q;
      logic [CNT_W-1:0] cnt_d;
      logic             sel_q;
      logic             sel_d;
      logic             off_q;
      logic             off_d;
      logic [CNT_W-1:0] limit;

      assign limit      = sel_q ? CNT_W'(OC_SHORT_CYC) : CNT_W'(OC_LONG_CYC);
      assign oc_trip[i] = sense_q.overcurrent[i] && drv_q[i] && (cnt_q == limit);
      assign oc_off[i]  = off_q;

      always_comb begin
        cnt_d = '0;
        sel_d = sel_q;
        if (sense_q.overcurrent[i] && drv_q[i]) begin
          if (cnt_q == '0) begin
            sel_d = cfg_q.overcurrent_delay_select;
            cnt_d = CNT_W'(1);
          end else if (cnt_q < limit) begin
            cnt_d = cnt_q + 1'b1;
          end else begin
            cnt_d = cnt_q;
          end
        end
        off_d = sticky(oc_trip[i], off_q, srr_clr);
        if (reset) begin
          cnt_d = '0;
          sel_d = 1'b0;
          off_d = 1'b0;
        end
      end

      always_ff @(posedge clk) begin
        cnt_q <= cnt_d;
        sel_q <= sel_d;
        off_q <= off_d;
      end
    end
  endgenerate

  assign ul_any     = |(sense_q.underload & drv_q);
  assign ul_expired = ul_any && (ul_cnt_q == CNT_W'(UL_CYC));
  assign uv_any     = |sense_q.undervoltage;
  assign ov_any     = |sense_q.overvoltage;
  assign tsd_any    = |sense_q.thermal_shutdown;
  // Forcing never touches cfg_q, so recovery needs no new command
  assign force_off  = uv_any || (ov_any && cfg_q.overvoltage_shutdown_enable) || tsd_any;

  // Shared underload timer and underload latch-off
  always_comb begin
    ul_cnt_d = '0;
    if (ul_any) begin
      // Saturates, so a later channel sees only what is left
      ul_cnt_d = (ul_cnt_q < CNT_W'(UL_CYC)) ? ul_cnt_q + 1'b1 : ul_cnt_q;
    end
    ul_off_d = (ul_off_q & ~{`HBF_N_OUT{srr_clr}}) |
               ({`HBF_N_OUT{ul_expired && cfg_q.underload_shutdown}} &
                sense_q.underload & drv_q);
    if (reset) begin
      ul_cnt_d = '0;
      ul_off_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    ul_cnt_q <= ul_cnt_d;
    ul_off_q <= ul_off_d;
  end

  // Drivers follow the stored pattern unless a fault holds them off
  always_comb begin
    drv_d = cfg_q.output_on & ~oc_off & ~ul_off_q & ~{`HBF_N_OUT{force_off}};
    if (reset) begin
      drv_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    drv_q <= drv_d;
  end

  // Latched flags and the driver image of the status word
  always_comb begin
    status_d = status_q;
    status_d.output_state         = drv_q;
    status_d.overload_flag        = sticky(|oc_trip, status_q.overload_flag, srr_clr);
    status_d.underload_flag       = sticky(ul_expired, status_q.underload_flag,
                                           srr_clr);
    status_d.supply_fail_flag     = sticky(uv_any || ov_any, status_q.supply_fail_flag,
                                           srr_clr);
    status_d.thermal_warning_flag = sticky(|sense_q.thermal_warn,
                                           status_q.thermal_warning_flag,
                                           srr_clr);
    if (reset) begin
      status_d = hbf_status_t'(`HBF_RST_WORD);
    end
  end

  always_ff @(posedge clk) begin
    status_q <= status_d;
  end

  // Serial output shifter
  always_comb begin
    // Bit zero sits at the pin before chip select falls, so no clock is needed
    if (sense_q.chip_select_n) begin
      tx_d = status_q;
    end else if (sclk_fall) begin
      tx_d = {1'b0, tx_q[`HBF_WORD_W-1:1]};
    end else begin
      tx_d = tx_q;
    end
    if (reset) begin
      tx_d = `HBF_RST_WORD;
    end
  end

  always_ff @(posedge clk) begin
    tx_q <= tx_d;
  end

  assign driver_output   = drv_q;
  assign serial_out      = tx_q[0];
  assign serial_out_oe_n = oe_n_q;
  assign status_word     = status_q;
  assign config_word     = cfg_q;
endmodule : hbf_protect
`default_nettype wire

// ---- dv/hbf_protect_monitor.sv ----
// Concurrent checks on the ports of the half-bridge fault logic
`include "hbf_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module hbf_protect_monitor
  import hbf_pkg::*;
#(
  parameter int OC_LONG_CYC = 200,
  parameter int UL_CYC      = 300
) (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire hbf_pkg::hbf_sense_t   sense_raw,
  input wire logic [`HBF_N_OUT-1:0] driver_output,
  input wire logic                  serial_out,
  input wire logic                  serial_out_oe_n,
  input wire hbf_pkg::hbf_status_t  status_word,
  input wire hbf_pkg::hbf_cmd_t     config_word
);
  logic       cs_q, cs_d;
  logic [3:0] since_q, since_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Cycles since chip select rose, saturating so long idle gaps stay cheap
  always_comb begin
    cs_d    = sense_raw.chip_select_n;
    since_d = (since_q == 4'hf) ? since_q : since_q + 4'h1;
    if (cs_d && !cs_q) begin
      since_d = 4'h0;
    end
  end
  always_ff @(posedge clk) begin
    cs_q    <= cs_d;
    since_q <= reset ? 4'hf : since_d;
  end
  sequence s_cs_idle;
    (sense_raw.chip_select_n && $stable(status_word))[*4];
  endsequence
  a_drive_follows: assert property (
    (driver_output & ~$past(config_word.output_on)) == '0) else $error("driver on unprogrammed");
  a_uv_shutdown: assert property (
    (sense_raw.undervoltage != '0)[*6] |-> driver_output == '0 && status_word.supply_fail_flag)
    else $error("undervoltage not handled");
  a_ov_flag: assert property (
    (sense_raw.overvoltage != '0)[*6] |-> status_word.supply_fail_flag) else $error("ov flag");
  a_ov_shutdown: assert property (
    (sense_raw.overvoltage != '0 && config_word.overvoltage_shutdown_enable)[*6]
    |-> driver_output == '0) else $error("ov shutdown");
  a_tw_flag: assert property (
    (sense_raw.thermal_warn != '0)[*6] |-> status_word.thermal_warning_flag) else $error("tw");
  a_tsd_all_off: assert property (
    (sense_raw.thermal_shutdown != '0)[*6] |-> driver_output == '0) else $error("tsd");
  a_flag_clear: assert property (
    ($fell(status_word.underload_flag) || $fell(status_word.supply_fail_flag)
     || $fell(status_word.overload_flag) || $fell(status_word.thermal_warning_flag))
    |-> since_q <= 4'ha) else $error("flag cleared away from frame end");
  a_early_level: assert property (
    s_cs_idle |-> serial_out == status_word.thermal_warning_flag) else $error("early bit");
  a_out_released: assert property (
    sense_raw.chip_select_n[*4] |-> serial_out_oe_n) else $error("so not released");
endmodule : hbf_protect_monitor
bind hbf_protect hbf_protect_monitor #(.OC_LONG_CYC(OC_LONG_CYC), .UL_CYC(UL_CYC)) u_monitor (
  .clk(clk), .reset(reset), .sense_raw(sense_raw), .driver_output(driver_output),
  .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .status_word(status_word),
  .config_word(config_word));
`default_nettype wire

// ---- dv/hbf_host_model.sv ----
// Host side of the serial link: sends command words and reads status bits
`timescale 1ns/10ps
`default_nettype none
module hbf_host_model (
  output logic      spi_clk,
  output logic      chip_select_n,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n
);
  logic [15:0] reply;
  logic        early;
  initial begin
    spi_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // Zero bits gives the early warning readout only; the device drops that frame
  task automatic send(input logic [15:0] w, input int nb);
    #37 chip_select_n = 1'b0;
    #60 early = serial_out;
    for (int i = 0; i < nb; i++) begin
      serial_in = w[15-i];
      #80 spi_clk = 1'b1;
      reply[i] = serial_out;
      #80 spi_clk = 1'b0;
    end
    serial_in = 1'b0;
    #80 chip_select_n = 1'b1;
    #1000;
  endtask : send
endmodule : hbf_host_model
`default_nettype wire

// ---- dv/test_hbf_protect.sv ----
// Self-checking bench of the half-bridge fault logic
`timescale 1ns/10ps
`default_nettype none
module test_hbf_protect;
  import hbf_pkg::*;
  localparam int OC = 200;
  localparam int UL = 300;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  hbf_sense_t  sn = '0;
  hbf_sense_t  sense_w;
  wire logic   sclk, csn, si, so, so_oe_n;
  logic [11:0] drv, on;
  hbf_status_t st;
  hbf_cmd_t    cfg;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #4 clk = ~clk;
  // Link pins reach the core through the sense struct too
  assign sense_w = {sn[$bits(hbf_sense_t)-1:2], sclk, csn};
  hbf_protect #(.OC_LONG_CYC(OC), .UL_CYC(UL)) dut (
    .clk(clk), .reset(reset), .spi_clk(sclk), .chip_select_n(csn), .serial_in(si),
    .sense_raw(sense_w), .driver_output(drv), .serial_out(so), .serial_out_oe_n(so_oe_n),
    .status_word(st), .config_word(cfg));
  hbf_host_model host (.spi_clk(sclk), .chip_select_n(csn), .serial_in(si),
    .serial_out(so), .serial_out_oe_n(so_oe_n));
  function automatic logic [15:0] cmd(logic ov, logic ul, logic sel, logic [11:0] o, logic r);
    return {ov, ul, sel, o, r};
  endfunction : cmd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Flags given as supply, underload, overload, warning
  task automatic exp_out(input logic [11:0] d, input logic [3:0] f);
    chk({4'h0, drv}, {4'h0, d});
    chk({12'h000, st.supply_fail_flag, st.underload_flag, st.overload_flag,
         st.thermal_warning_flag}, {12'h000, f});
  endtask : exp_out
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold
  task automatic frame(input logic [15:0] w);
    host.send(w, 16);
    hold(2);
  endtask : frame
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    void'($urandom(83));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    hold(3);
    for (int k = 0; k < 3; k++) begin
      on = 12'($urandom) | 12'h00f;
      frame(cmd(0, 0, 0, on, 0));
      chk(cfg, cmd(0, 0, 0, on, 0));
    end
    $display("test config done");
    @(posedge clk) sn.overcurrent <= 12'h001;
    hold(OC - 50);
    exp_out(on, 4'h0);
    hold(100);
    exp_out(on & 12'hffe, 4'h2);
    frame(cmd(0, 0, 1, on, 0));
    @(posedge clk) sn.overcurrent <= 12'h003;
    frame(cmd(0, 0, 0, on, 0));
    hold(100);
    exp_out(on & 12'hffe, 4'h2);
    hold(2700);
    exp_out(on & 12'hffc, 4'h2);
    @(posedge clk) sn.overcurrent <= 12'h000;
    frame(cmd(0, 0, 0, on, 1));
    exp_out(on, 4'h0);
    $display("test overcurrent done");
    @(posedge clk) sn.underload <= 12'h004;
    hold(UL / 2);
    @(posedge clk) sn.underload <= 12'h00c;
    hold(UL / 2 + 20);
    exp_out(on, 4'h4);
    @(posedge clk) sn.underload <= 12'h000;
    frame(cmd(0, 1, 0, on, 1));
    exp_out(on, 4'h0);
    @(posedge clk) sn.underload <= 12'h004;
    hold(UL - 100);
    @(posedge clk) sn.underload <= 12'h00c;
    hold(120);
    exp_out(on & 12'hff3, 4'h4);
    @(posedge clk) sn.underload <= 12'h000;
    frame(cmd(0, 0, 0, on, 1));
    exp_out(on, 4'h0);
    $display("test underload done");
    @(posedge clk) sn.undervoltage <= 2'h1;
    hold(10);
    exp_out(12'h000, 4'h8);
    chk({4'h0, cfg.output_on}, {4'h0, on});
    @(posedge clk) sn.undervoltage <= 2'h0;
    hold(10);
    exp_out(on, 4'h8);
    @(posedge clk) sn.overvoltage <= 2'h2;
    hold(10);
    exp_out(on, 4'h8);
    frame(cmd(1, 0, 0, on, 0));
    exp_out(12'h000, 4'h8);
    @(posedge clk) sn.overvoltage <= 2'h0;
    hold(10);
    exp_out(on, 4'h8);
    frame(cmd(0, 0, 0, on, 1));
    exp_out(on, 4'h0);
    $display("test supply done");
    @(posedge clk) sn.thermal_warn <= 6'h20;
    hold(10);
    exp_out(on, 4'h1);
    @(posedge clk) sn.thermal_warn <= 6'h00;
    hold(10);
    exp_out(on, 4'h1);
    host.send(16'h0000, 0);
    chk({15'h0000, host.early}, 16'h0001);
    frame(cmd(0, 0, 0, on, 1));
    chk({15'h0000, host.reply[0]}, 16'h0001);
    exp_out(on, 4'h0);
    host.send(16'h0000, 0);
    chk({15'h0000, host.early}, 16'h0000);
    $display("test warning done");
    @(posedge clk) sn.thermal_shutdown <= 6'h04;
    hold(10);
    exp_out(12'h000, 4'h0);
    on = 12'($urandom) | 12'h001;
    frame(cmd(0, 0, 0, on, 0));
    exp_out(12'h000, 4'h0);
    @(posedge clk) sn.thermal_shutdown <= 6'h00;
    hold(10);
    exp_out(on, 4'h0);
    $display("test shutdown done");
    close_out();
  end
endmodule : test_hbf_protect
`default_nettype wire
